// *** psl_pkg.sv ***
// package: constants and carriers for the parameter set loader and service port
package psl_pkg;
	localparam int      CLK_HZ         = 20000000;
	localparam int      BAUD           = 9600;
	localparam int      BIT_CYCLES     = CLK_HZ / BAUD;
	localparam int      DATA_BITS      = 8;
	localparam int      STOP_BITS      = 1;
	localparam int      SELFTEST_US    = 100;
	localparam int      SELFTEST_CYC   = (SELFTEST_US * (CLK_HZ / 1000000));
	localparam int      FLASH_MS       = 250;
	localparam int      FLASH_CYC      = FLASH_MS * (CLK_HZ / 1000);
	localparam int      PSET_WORDS     = 16;
	localparam int      FIFO_DEPTH     = 32;
	localparam logic [7:0] CHAR_STX    = 8'h02;
	localparam logic [7:0] CHAR_CR     = 8'h0d;
	localparam logic [7:0] CHAR_LF     = 8'h0a;
	localparam logic [1:0] LED_OFF     = 2'h0;
	localparam logic [1:0] LED_GREEN   = 2'h1;
	localparam logic [1:0] LED_RED     = 2'h2;
	localparam logic [1:0] LED_ORANGE  = 2'h3;

	// one byte with its framing-fault mark
	typedef struct packed {
		logic       frame_err;
		logic [7:0] data;
	} rx_byte_t;

	// storage access request to ROM or nonvolatile store
	typedef struct packed {
		logic       wr;
		logic [3:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
endpackage

// *** psl_fifo.sv ***
// fifo: parameterised flip-flop buffer with valid and ready on both sides
`timescale 1ns/10ps
module psl_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wp_ff;
	logic [AW:0]      rp_ff;
	logic             push;
	logic             pop;

	// honest full and empty from pointer compare
	assign in_ready  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
	assign out_valid = wp_ff != rp_ff;
	assign out_data  = mem_ff[rp_ff[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			if (push) wp_ff <= wp_ff + 1'b1;
			if (pop) rp_ff <= rp_ff + 1'b1;
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (push) mem_ff[wp_ff[AW-1:0]] <= in_data;
	end
endmodule

// *** psl_loader.sv ***
// top: parameter set selection and load, service uart and status indicator
`timescale 1ns/10ps
// Notes on behaviour
// - verify checksum of a set before copying; never use a failing set
// - load factory set on first commissioning, factory command, or bad stored set
// - load stored current set at power up and after software reset
// - parameter reset overwrites stored current set with factory values
// - host words written straight into the stored set while HOST_SET_VALID is held in service mode; no checksum or completeness check
// - service port runs 9600 baud, 8 data, no parity, 1 stop
// - service framing fixed, ignores stored serial configuration
// - service mode only while the strap is held at ground
// - only transmit, receive and ground; no rts/cts flow control
// - green ready shown only after power-on self test completes
// - led: flashing green init, green normal, red error, orange service
// - service strap is active low
module psl_loader
	import psl_pkg::*;
#(
	parameter int SELFTEST_CYCLES = SELFTEST_CYC,
	parameter int FLASH_CYCLES    = FLASH_CYC,
	parameter int WORDS           = PSET_WORDS
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        SW_RESET,
	input  wire logic        FACTORY_CMD,
	input  wire logic        PARAM_RESET,
	input  wire logic        FIRST_COMMISSION,
	input  wire logic        HOST_SET_VALID,
	input  wire logic        HOST_WR,
	input  wire logic [3:0]  HOST_ADDR,
	input  wire logic [15:0] HOST_DATA,
	input  wire logic [15:0] ROM_RDATA,
	input  wire logic [15:0] NV_RDATA,
	output logic [3:0]       ROM_ADDR,
	output logic             NV_WR,
	output logic [3:0]       NV_ADDR,
	output logic [15:0]      NV_WDATA,
	output logic             WORK_WR,
	output logic [3:0]       WORK_ADDR,
	output logic [15:0]      WORK_DATA,
	output logic             LOAD_DONE,
	output logic             USING_FACTORY,
	output logic             PARAM_ERROR,
	input  wire logic        service_strap_n,
	input  wire logic        SERVICE_STRAP_N_RXD,
	output logic             SERVICE_STRAP_N_TXD,
	output logic [7:0]       RX_DATA,
	output logic             RX_VALID,
	input  wire logic        RX_READY,
	input  wire logic [7:0]  TX_DATA,
	input  wire logic        TX_VALID,
	output logic             TX_READY,
	output logic [1:0]       LED
);
	initial begin
		if (WORDS != 16) $error("parameter set must be sixteen words");
		if (SELFTEST_CYCLES < 1 || FLASH_CYCLES < 2) $error("bad timing counts");
	end

	typedef enum {S_TEST, S_CHECK, S_COPY, S_RESTORE, S_HOSTWR, S_RUN, S_FAIL} ld_state_t;
	ld_state_t   st_ff;
	logic        src_rom_ff;
	logic [4:0]  idx_ff;
	logic [15:0] sum_ff;
	logic [31:0] tcnt_ff;
	logic        test_done_ff;
	logic [15:0] rd;

	// strap and rxd synchronisers
	logic [1:0]  strap_sy_ff;
	logic [1:0]  rxd_sy_ff;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			strap_sy_ff <= 2'h3;
			rxd_sy_ff   <= 2'h3;
		end else begin
			strap_sy_ff <= {strap_sy_ff[0], service_strap_n};
			rxd_sy_ff   <= {rxd_sy_ff[0], SERVICE_STRAP_N_RXD};
		end
	end
	logic service;
	assign service = ~strap_sy_ff[1];

	assign rd = src_rom_ff ? ROM_RDATA : NV_RDATA;

	// load sequencer: checksum scan, then copy into working copy
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff         <= S_TEST;
			src_rom_ff    <= 1'b0;
			idx_ff        <= '0;
			sum_ff        <= '0;
			tcnt_ff       <= '0;
			test_done_ff  <= 1'b0;
			LOAD_DONE     <= 1'b0;
			USING_FACTORY <= 1'b0;
			PARAM_ERROR   <= 1'b0;
			NV_WR         <= 1'b0;
			NV_ADDR       <= '0;
			NV_WDATA      <= '0;
			WORK_WR       <= 1'b0;
			WORK_ADDR     <= '0;
			WORK_DATA     <= '0;
			ROM_ADDR      <= '0;
		end else begin
			NV_WR   <= 1'b0;
			WORK_WR <= 1'b0;
			case (st_ff)
				S_TEST: begin
					tcnt_ff <= tcnt_ff + 1;
					if (tcnt_ff >= 32'(SELFTEST_CYCLES - 1)) begin
						test_done_ff <= 1'b1;
						src_rom_ff   <= FIRST_COMMISSION;
						idx_ff       <= '0;
						sum_ff       <= '0;
						st_ff        <= S_CHECK;
					end
				end
				S_CHECK: begin
					// words 0..14 summed must equal word 15
					ROM_ADDR <= idx_ff[3:0] + 4'h1;
					NV_ADDR  <= idx_ff[3:0] + 4'h1;
					if (idx_ff == 5'h0f) begin
						idx_ff <= '0;
						if (sum_ff == rd) begin
							st_ff <= S_COPY;
							ROM_ADDR <= '0;
							NV_ADDR  <= '0;
						end else if (!src_rom_ff) begin
							src_rom_ff <= 1'b1;
							sum_ff     <= '0;
							ROM_ADDR   <= '0;
						end else begin
							PARAM_ERROR <= 1'b1;
							st_ff       <= S_FAIL;
						end
					end else begin
						sum_ff <= sum_ff + rd;
						idx_ff <= idx_ff + 5'h1;
					end
				end
				S_COPY: begin
					WORK_WR   <= 1'b1;
					WORK_ADDR <= idx_ff[3:0];
					WORK_DATA <= rd;
					ROM_ADDR  <= idx_ff[3:0] + 4'h1;
					NV_ADDR   <= idx_ff[3:0] + 4'h1;
					idx_ff    <= idx_ff + 5'h1;
					if (idx_ff == 5'h0f) begin
						LOAD_DONE     <= 1'b1;
						USING_FACTORY <= src_rom_ff;
						PARAM_ERROR   <= 1'b0;
						st_ff         <= S_RUN;
					end
				end
				S_RESTORE: begin
					// factory word written one cycle behind its read
					NV_WR    <= 1'b1;
					NV_WDATA <= ROM_RDATA;
					NV_ADDR  <= ROM_ADDR;
					ROM_ADDR <= ROM_ADDR + 4'h1;
					idx_ff   <= idx_ff + 5'h1;
					if (idx_ff == 5'h0f) st_ff <= S_RUN;
				end
				S_HOSTWR: begin
					if (HOST_WR) begin
						NV_WR    <= 1'b1;
						NV_ADDR  <= HOST_ADDR;
						NV_WDATA <= HOST_DATA;
					end
					if (!HOST_SET_VALID) st_ff <= S_RUN;
				end
				S_RUN, S_FAIL: begin
					if (SW_RESET) begin
						src_rom_ff <= 1'b0;
						LOAD_DONE  <= 1'b0;
						idx_ff     <= '0;
						sum_ff     <= '0;
						ROM_ADDR   <= '0;
						NV_ADDR    <= '0;
						st_ff      <= S_CHECK;
					end else if (FACTORY_CMD) begin
						src_rom_ff <= 1'b1;
						LOAD_DONE  <= 1'b0;
						idx_ff     <= '0;
						sum_ff     <= '0;
						ROM_ADDR   <= '0;
						st_ff      <= S_CHECK;
					end else if (PARAM_RESET) begin
						idx_ff   <= '0;
						ROM_ADDR <= '0;
						st_ff    <= S_RESTORE;
					end else if (HOST_SET_VALID && service) begin
						st_ff <= S_HOSTWR;
					end
				end
				default: st_ff <= S_TEST;
			endcase
		end
	end

	// receiver: fixed 8n1 at 9600, independent of stored config
	logic [15:0] rbit_ff;
	logic [3:0]  rcnt_ff;
	logic [7:0]  rsh_ff;
	logic        rbusy_ff;
	rx_byte_t    rbyte_ff;
	logic        rpush_ff;
	logic        fifo_in_ready;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rbit_ff  <= '0;
			rcnt_ff  <= '0;
			rsh_ff   <= '0;
			rbusy_ff <= 1'b0;
			rbyte_ff <= '0;
			rpush_ff <= 1'b0;
		end else begin
			rpush_ff <= 1'b0;
			if (!rbusy_ff) begin
				if (service && !rxd_sy_ff[1]) begin
					rbusy_ff <= 1'b1;
					rbit_ff  <= 16'(BIT_CYCLES / 2);
					rcnt_ff  <= '0;
				end
			end else if (rbit_ff != 0) begin
				rbit_ff <= rbit_ff - 16'h1;
			end else begin
				rbit_ff <= 16'(BIT_CYCLES - 1);
				rcnt_ff <= rcnt_ff + 4'h1;
				if (rcnt_ff == 4'(DATA_BITS + STOP_BITS)) begin
					rbusy_ff       <= 1'b0;
					rbyte_ff.data  <= rsh_ff;
					rbyte_ff.frame_err <= ~rxd_sy_ff[1];
					rpush_ff       <= fifo_in_ready & rxd_sy_ff[1]; // drop bad framing
				end else if (rcnt_ff == 4'h0) begin
					if (rxd_sy_ff[1]) rbusy_ff <= 1'b0; // false start
				end else begin
					rsh_ff <= {rxd_sy_ff[1], rsh_ff[7:1]}; // lsb first, no parity
				end
			end
		end
	end

	// receive buffer of 32 bytes toward the command parser
	logic [8:0] fo_data;
	logic       fo_valid;
	psl_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk       (CLK),
		.rst_n     (RST_N),
		.in_data   (rbyte_ff),
		.in_valid  (rpush_ff),
		.in_ready  (fifo_in_ready),
		.out_data  (fo_data),
		.out_valid (fo_valid),
		.out_ready (RX_READY & ~RX_VALID)
	);
	// output stage registered
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RX_VALID <= 1'b0;
			RX_DATA  <= '0;
		end else if (RX_VALID) begin
			RX_VALID <= 1'b0;
		end else if (fo_valid && RX_READY) begin
			RX_VALID <= 1'b1;
			RX_DATA  <= fo_data[7:0];
		end
	end

	// transmitter: sends STX before the first caller byte of a message; message ends after a caller LF
	logic [15:0] tbit_ff;
	logic [3:0]  tcnt2_ff;
	logic [9:0]  tsh_ff;
	logic        tbusy_ff;
	logic        in_msg_ff;
	logic [7:0]  tpend_ff;
	logic        tpend_v_ff;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tbit_ff    <= '0;
			tcnt2_ff   <= '0;
			tsh_ff     <= '1;
			tbusy_ff   <= 1'b0;
			in_msg_ff  <= 1'b0;
			tpend_ff   <= '0;
			tpend_v_ff <= 1'b0;
			TX_READY   <= 1'b0;
			SERVICE_STRAP_N_TXD   <= 1'b1;
		end else begin
			TX_READY <= service & ~tbusy_ff & ~tpend_v_ff & ~TX_READY;
			if (TX_READY && TX_VALID) begin
				tpend_ff   <= TX_DATA;
				tpend_v_ff <= 1'b1;
			end
			if (tbusy_ff) begin
				if (tbit_ff != 0) begin
					tbit_ff <= tbit_ff - 16'h1;
				end else begin
					tbit_ff  <= 16'(BIT_CYCLES - 1);
					tsh_ff   <= {1'b1, tsh_ff[9:1]};
					tcnt2_ff <= tcnt2_ff + 4'h1;
					if (tcnt2_ff == 4'(DATA_BITS + STOP_BITS)) tbusy_ff <= 1'b0;
				end
			end else if (!in_msg_ff && tpend_v_ff) begin
				tsh_ff   <= {1'b1, CHAR_STX, 1'b0};
				in_msg_ff <= 1'b1;
				tbusy_ff <= 1'b1;
				tbit_ff  <= 16'(BIT_CYCLES - 1);
				tcnt2_ff <= '0;
			end else if (tpend_v_ff) begin
				tsh_ff     <= {1'b1, tpend_ff, 1'b0};
				tpend_v_ff <= 1'b0;
				in_msg_ff  <= (tpend_ff != CHAR_LF);
				tbusy_ff   <= 1'b1;
				tbit_ff    <= 16'(BIT_CYCLES - 1);
				tcnt2_ff   <= '0;
			end
			SERVICE_STRAP_N_TXD <= service ? tsh_ff[0] : 1'b1;
		end
	end

	// status indicator with flash divider
	logic [31:0] fcnt_ff;
	logic        flash_ff;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fcnt_ff  <= '0;
			flash_ff <= 1'b0;
			LED      <= LED_OFF;
		end else begin
			if (fcnt_ff >= 32'(FLASH_CYCLES - 1)) begin
				fcnt_ff  <= '0;
				flash_ff <= ~flash_ff;
			end else begin
				fcnt_ff <= fcnt_ff + 1;
			end
			if (service && test_done_ff) LED <= LED_ORANGE;
			else if (PARAM_ERROR) LED <= LED_RED;
			else if (LOAD_DONE && test_done_ff) LED <= LED_GREEN;
			else LED <= flash_ff ? LED_GREEN : LED_OFF;
		end
	end
endmodule

// *** psl_loader_assertions.sv ***
// checker: port-level properties of the parameter loader
`timescale 1ns/10ps
module psl_loader_assertions
	import psl_pkg::*;
#(
	parameter int SELFTEST_CYCLES = 10
) (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       SW_RESET,
	input wire logic       FACTORY_CMD,
	input wire logic       PARAM_RESET,
	input wire logic       service_strap_n,
	input wire logic       PARAM_ERROR,
	input wire logic       LOAD_DONE,
	input wire logic       WORK_WR,
	input wire logic [3:0] WORK_ADDR,
	input wire logic       RX_VALID,
	input wire logic       SERVICE_STRAP_N_TXD,
	input wire logic [1:0] LED
);
	int cyc_ff;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// cycles since reset, saturating at the self-test length
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cyc_ff <= 0;
		end else if (cyc_ff < SELFTEST_CYCLES) begin
			cyc_ff <= cyc_ff + 1;
		end
	end
	property p_svc_off;
		service_strap_n [*8] |-> LED != LED_ORANGE;
	endproperty
	a_svc_off: assert property (p_svc_off) else $error("orange without strap");
	property p_red;
		(PARAM_ERROR && service_strap_n) [*5] |-> LED == LED_RED;
	endproperty
	a_red: assert property (p_red) else $error("error not red");
	property p_hold;
		LOAD_DONE && !SW_RESET && !FACTORY_CMD |=> LOAD_DONE;
	endproperty
	a_hold: assert property (p_hold) else $error("load done dropped");
	property p_selftest;
		$rose(LOAD_DONE) |-> cyc_ff >= SELFTEST_CYCLES;
	endproperty
	a_selftest: assert property (p_selftest) else $error("ready before self test");
	property p_copy;
		$rose(WORK_WR) |-> WORK_ADDR == 4'h0 ##15 (WORK_WR && WORK_ADDR == 4'hf) ##1 !WORK_WR;
	endproperty
	a_copy: assert property (p_copy) else $error("copy burst wrong");
	property p_done;
		$fell(WORK_WR) |-> ##[0:2] LOAD_DONE;
	endproperty
	a_done: assert property (p_done) else $error("no done after copy");
	property p_rx;
		RX_VALID |=> !RX_VALID;
	endproperty
	a_rx: assert property (p_rx) else $error("rx valid too long");
	property p_start;
		$fell(SERVICE_STRAP_N_TXD) |-> !SERVICE_STRAP_N_TXD [*8];
	endproperty
	a_start: assert property (p_start) else $error("start bit short");
	// main scenarios reached
	cover property (LED == LED_ORANGE);
	cover property (PARAM_ERROR);
	cover property ($fell(WORK_WR));
	cover property (PARAM_RESET && LOAD_DONE);
endmodule
bind psl_loader psl_loader_assertions #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (.CLK, .RST_N,
	.SW_RESET, .FACTORY_CMD, .PARAM_RESET, .service_strap_n, .PARAM_ERROR, .LOAD_DONE,
	.WORK_WR, .WORK_ADDR, .RX_VALID, .SERVICE_STRAP_N_TXD, .LED);

// *** psl_terminal.sv ***
// partner: service terminal sending and receiving 8n1 frames
`timescale 1ns/10ps
module psl_terminal
	import psl_pkg::*;
(
	input  wire logic clk,
	input  wire logic txd,
	output logic      rxd
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// one frame, lsb first, idle at mark
	task automatic send(input logic [7:0] d);
		for (int i = 0; i < 10; i++) begin
			rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
			repeat (BIT_CYCLES) @(negedge clk);
		end
	endtask
	// receive: sample mid-bit, keep bytes with a good stop bit
	initial begin
		rxd = 1'b1;
		forever begin
			@(negedge txd);
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				if (i < 8) sh[i] = txd;
				else if (txd) got.push_back(sh);
			end
		end
	end
endmodule

// *** tb_top.sv ***
// testbench: loader, service port and indicator against a bench model
`timescale 1ns/10ps
module tb_top;
	import psl_pkg::*;
	typedef logic [15:0] set_t [16];
	logic        CLK, RST_N, SW_RESET, FACTORY_CMD, PARAM_RESET, FIRST_COMMISSION;
	logic        HOST_SET_VALID, HOST_WR, service_strap_n, RX_READY, TX_VALID, RXD, TXD;
	logic        NV_WR, WORK_WR, LOAD_DONE, USING_FACTORY, PARAM_ERROR, RX_VALID, TX_READY;
	logic [3:0]  HOST_ADDR, ROM_ADDR, NV_ADDR, WORK_ADDR;
	logic [15:0] HOST_DATA, NV_WDATA, WORK_DATA;
	logic [7:0]  RX_DATA, TX_DATA, b;
	logic [1:0]  LED;
	set_t        rom, nv, work, exp;
	int          failures, n_checks, nwr, cyc;
	psl_loader #(.SELFTEST_CYCLES(10), .FLASH_CYCLES(8)) DUT (.CLK, .RST_N, .SW_RESET,
		.FACTORY_CMD, .PARAM_RESET, .FIRST_COMMISSION, .HOST_SET_VALID, .HOST_WR, .HOST_ADDR,
		.HOST_DATA, .ROM_RDATA(rom[ROM_ADDR]), .NV_RDATA(nv[NV_ADDR]), .ROM_ADDR, .NV_WR,
		.NV_ADDR, .NV_WDATA, .WORK_WR, .WORK_ADDR, .WORK_DATA, .LOAD_DONE, .USING_FACTORY,
		.PARAM_ERROR, .service_strap_n, .SERVICE_STRAP_N_RXD(RXD), .SERVICE_STRAP_N_TXD(TXD), .RX_DATA, .RX_VALID,
		.RX_READY, .TX_DATA, .TX_VALID, .TX_READY, .LED);
	psl_terminal term (.clk(CLK), .txd(TXD), .rxd(RXD));
	// clock
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// storage, working copy and run limit
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (NV_WR) nv[NV_ADDR] <= NV_WDATA;
		if (WORK_WR) work[WORK_ADDR] <= WORK_DATA;
		if (WORK_WR) nwr <= nwr + 1;
		if (cyc == 95000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("Error %0t: %s", $time, m);
		end
	endtask
	function automatic logic same(set_t a, set_t c);
		same = 1'b1;
		for (int i = 0; i < 16; i++) if (a[i] !== c[i]) same = 1'b0;
	endfunction
	// random set whose last word is the wrapped sum of the rest
	function automatic set_t mk();
		mk[15] = 16'h0;
		for (int i = 0; i < 15; i++) begin
			mk[i] = 16'($urandom);
			mk[15] += mk[i];
		end
	endfunction
	function automatic logic cnd(int k);
		case (k)
			0: cnd = LOAD_DONE;
			1: cnd = !LOAD_DONE;
			2: cnd = PARAM_ERROR;
			3: cnd = RX_VALID;
			4: cnd = same(nv, exp);
			default: cnd = (term.got.size() == 3);
		endcase
	endfunction
	task automatic wt(int k);
		for (int i = 0; i < 25000 && cnd(k) !== 1'b1; i++) @(negedge CLK);
		chk(cnd(k), "wait ran out");
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		nwr = 0;
		@(negedge CLK);
		s = 1'b0;
		wt(1);
		wt(0);
		@(negedge CLK);
	endtask
	task automatic rst();
		RST_N = 1'b0;
		nwr = 0;
		repeat (2) @(negedge CLK);
		RST_N = 1'b1;
	endtask
	task automatic tx(input logic [7:0] d);
		TX_DATA = d;
		TX_VALID = 1'b1;
		for (int i = 0; i < 50000 && TX_READY !== 1'b1; i++) @(negedge CLK);
		chk(TX_READY === 1'b1, "no transmit offer");
		@(negedge CLK);
	endtask
	initial begin
		void'($urandom(32'h0c13));
		{SW_RESET, FACTORY_CMD, PARAM_RESET, FIRST_COMMISSION, HOST_SET_VALID} = '0;
		{HOST_WR, TX_VALID, HOST_ADDR, HOST_DATA, TX_DATA} = '0;
		{RST_N, service_strap_n, RX_READY} = 3'h3;
		{failures, n_checks, cyc} = '0;
		rom = mk();
		nv = mk();
		rst();
		wt(0);
		repeat (3) @(negedge CLK);
		chk(same(work, nv) && nwr == 16 && !USING_FACTORY, "power-up set");
		chk(LED === LED_GREEN, "ready led");
		pulse(FACTORY_CMD);
		chk(same(work, rom) && USING_FACTORY, "factory set");
		pulse(SW_RESET);
		chk(same(work, nv) && nwr == 16, "soft reset set");
		nv[3] ^= 16'h1;
		pulse(SW_RESET);
		chk(same(work, rom) && nwr == 16, "bad stored set");
		exp = rom;
		PARAM_RESET = 1'b1;
		@(negedge CLK);
		PARAM_RESET = 1'b0;
		wt(4);
		wt(0);
		nv = mk();
		work = nv;
		FIRST_COMMISSION = 1'b1;
		rst();
		wt(0);
		@(negedge CLK);
		chk(same(work, rom) && nwr == 16, "first commissioning");
		FIRST_COMMISSION = 1'b0;
		service_strap_n = 1'b0;
		repeat (6) @(negedge CLK);
		chk(LED === LED_ORANGE, "service led");
		exp = mk();
		HOST_SET_VALID = 1'b1;
		@(negedge CLK);
		for (int i = 0; i < 16; i++) begin
			HOST_WR = 1'b1;
			HOST_ADDR = 4'(i);
			HOST_DATA = exp[i];
			@(negedge CLK);
		end
		HOST_WR = 1'b0;
		wt(4);
		HOST_SET_VALID = 1'b0;
		b = 8'($urandom);
		RX_READY = 1'b0;
		fork
			term.send(b);
			begin
				tx(CHAR_CR);
				tx(CHAR_LF);
				TX_VALID = 1'b0;
			end
		join
		RX_READY = 1'b1;
		wt(3);
		chk(RX_DATA === b, "rx byte");
		wt(5);
		chk(term.got[0] === CHAR_STX && term.got[1] === CHAR_CR, "prefix");
		chk(term.got[2] === CHAR_LF, "postfix");
		service_strap_n = 1'b1;
		repeat (6) @(negedge CLK);
		chk(LED === LED_GREEN, "normal led");
		pulse(SW_RESET);
		chk(same(work, exp), "host set in use");
		nv[0] ^= 16'h1;
		rom[0] ^= 16'h1;
		rst();
		wt(2);
		repeat (6) @(negedge CLK);
		chk(LED === LED_RED && !LOAD_DONE && nwr == 0, "both sets bad");
		end_of_test();
	end
endmodule
